// ===== rtl/agc_pkg.sv
/*
  Constants for the angle path with axis gain correction.
  Assumes a single 25 MHz clock domain and signed 16-bit axis codes.
*/
package agc_pkg;

  // ----------------------------------------------------------------
  // Field encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] AGC_TGT_NONE = 2'h0;
  localparam logic [1:0] AGC_TGT_X = 2'h1;
  localparam logic [1:0] AGC_TGT_Y = 2'h2;
  localparam logic [1:0] AGC_AXIS_X = 2'h0;
  localparam logic [1:0] AGC_AXIS_Y = 2'h1;
  localparam logic [1:0] AGC_AXIS_Z = 2'h2;
  localparam logic [1:0] AGC_PAIR_XY = 2'h1;
  localparam logic [1:0] AGC_PAIR_YZ = 2'h2;
  localparam logic [1:0] AGC_PAIR_XZ = 2'h3;

  // ----------------------------------------------------------------
  // Widths and scaling
  // ----------------------------------------------------------------
  localparam int AGC_GAIN_W = 10;
  localparam int AGC_GAIN_SHIFT = 10;
  localparam int AGC_ANG_W = 16;
  localparam int AGC_ITER = 14;

  typedef enum logic [2:0] {
    AGC_ST_IDLE = 3'b001,
    AGC_ST_ROT = 3'b010,
    AGC_ST_DONE = 3'b100
  } agc_state_e;

endpackage

// ===== rtl/agc_angle_axis.sv
/*
  Angle calculator: picks two axes, applies gain, runs a vectoring CORDIC.
  Assumes conv_done is a one-cycle pulse on clk when new axis codes are valid.
*/
`timescale 1ns/1ns
`default_nettype none
module agc_angle_axis
  import agc_pkg::*;
#(
  parameter int DATA_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  // Configuration
  input wire logic [1:0] angle_axis_sel,
  input wire logic [1:0] gain_target_sel,
  input wire logic [AGC_GAIN_W-1:0] gain_value,
  // Axis codes from conversion
  input wire logic conv_done,
  input wire logic signed [DATA_W-1:0] axis_x,
  input wire logic signed [DATA_W-1:0] axis_y,
  input wire logic signed [DATA_W-1:0] axis_z,
  // Results
  output logic [AGC_ANG_W-1:0] angle_result,
  output logic [DATA_W+1:0] magnitude_result,
  output logic result_valid,
  output logic alert_conv_done
);

  localparam int W = DATA_W + 3;
  localparam int IW = $clog2(AGC_ITER + 1);
  // Half turn added when the vector is folded
  localparam logic [AGC_ANG_W-1:0] HALF_TURN = {1'b1, {(AGC_ANG_W-1){1'b0}}};

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic signed [DATA_W-1:0] pick(
    input logic [1:0] ax,
    input logic signed [DATA_W-1:0] x,
    input logic signed [DATA_W-1:0] y,
    input logic signed [DATA_W-1:0] z
  );
    case (ax)
      AGC_AXIS_X: pick = x;
      AGC_AXIS_Y: pick = y;
      default: pick = z;
    endcase
  endfunction

  function automatic logic signed [DATA_W-1:0] scale(
    input logic signed [DATA_W-1:0] v,
    input logic [AGC_GAIN_W-1:0] g
  );
    logic signed [DATA_W+AGC_GAIN_W:0] p;
    p = v * $signed({1'b0, g});
    scale = p[AGC_GAIN_SHIFT +: DATA_W];
  endfunction

  // Atan table, full circle mapped to 2^AGC_ANG_W
  function automatic logic [AGC_ANG_W-1:0] atan_lut(input logic [IW-1:0] i);
    case (i)
      0: atan_lut = 16'h2000;
      1: atan_lut = 16'h12E4;
      2: atan_lut = 16'h09FB;
      3: atan_lut = 16'h0511;
      4: atan_lut = 16'h028B;
      5: atan_lut = 16'h0146;
      6: atan_lut = 16'h00A3;
      7: atan_lut = 16'h0051;
      8: atan_lut = 16'h0029;
      9: atan_lut = 16'h0014;
      10: atan_lut = 16'h000A;
      11: atan_lut = 16'h0005;
      12: atan_lut = 16'h0003;
      13: atan_lut = 16'h0001;
      default: atan_lut = 16'h0000;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Axis selection and gain
  // ----------------------------------------------------------------
  logic [1:0] ax_a;
  logic [1:0] ax_b;
  always_comb begin
    case (angle_axis_sel)
      AGC_PAIR_YZ: begin
        ax_a = AGC_AXIS_Y;
        ax_b = AGC_AXIS_Z;
      end
      AGC_PAIR_XZ: begin
        ax_a = AGC_AXIS_X;
        ax_b = AGC_AXIS_Z;
      end
      default: begin
        ax_a = AGC_AXIS_X;
        ax_b = AGC_AXIS_Y;
      end
    endcase
  end

  logic signed [DATA_W-1:0] raw_a;
  logic signed [DATA_W-1:0] raw_b;
  logic signed [DATA_W-1:0] in_a;
  logic signed [DATA_W-1:0] in_b;
  assign raw_a = pick(ax_a, axis_x, axis_y, axis_z);
  assign raw_b = pick(ax_b, axis_x, axis_y, axis_z);

  always_comb begin
    in_a = raw_a;
    in_b = raw_b;
    case (gain_target_sel)
      AGC_TGT_X: in_a = scale(raw_a, gain_value);
      AGC_TGT_Y: in_b = scale(raw_b, gain_value);
      default: begin
        in_a = raw_a;
        in_b = raw_b;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Vectoring CORDIC
  // ----------------------------------------------------------------
  agc_state_e state_ff;
  logic signed [W-1:0] cx_ff;
  logic signed [W-1:0] cy_ff;
  logic [AGC_ANG_W-1:0] cz_ff;
  logic [IW-1:0] iter_ff;

  // ----------------------------------------------------------------
  // Rotator step decode
  // ----------------------------------------------------------------
  logic fold;
  logic iter_last;
  logic done_st;
  logic signed [W-1:0] dx;
  logic signed [W-1:0] dy;
  logic [AGC_ANG_W-1:0] step_ang;
  assign fold = in_a[DATA_W-1];
  assign iter_last = (iter_ff == IW'(AGC_ITER - 1));
  assign done_st = (state_ff == AGC_ST_DONE);
  assign dx = cx_ff >>> iter_ff;
  assign dy = cy_ff >>> iter_ff;
  assign step_ang = atan_lut(iter_ff);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= AGC_ST_IDLE;
      cx_ff <= '0;
      cy_ff <= '0;
      cz_ff <= '0;
      iter_ff <= '0;
    end else if (clk_en) begin
      case (state_ff)
        AGC_ST_IDLE: begin
          if (conv_done) begin
            // Fold left half plane to cover the full circle
            if (fold) begin
              cx_ff <= -W'(in_a);
              cy_ff <= -W'(in_b);
              cz_ff <= HALF_TURN;
            end else begin
              cx_ff <= W'(in_a);
              cy_ff <= W'(in_b);
              cz_ff <= '0;
            end
            iter_ff <= '0;
            state_ff <= AGC_ST_ROT;
          end
        end
        AGC_ST_ROT: begin
          if (cy_ff < 0) begin
            cx_ff <= cx_ff - dy;
            cy_ff <= cy_ff + dx;
            cz_ff <= cz_ff - step_ang;
          end else begin
            cx_ff <= cx_ff + dy;
            cy_ff <= cy_ff - dx;
            cz_ff <= cz_ff + step_ang;
          end
          if (iter_last) begin
            state_ff <= AGC_ST_DONE;
          end
          iter_ff <= iter_ff + 1'b1;
        end
        AGC_ST_DONE: state_ff <= AGC_ST_IDLE;
        default: state_ff <= AGC_ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Result registers and alert
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      angle_result <= '0;
      magnitude_result <= '0;
      result_valid <= 1'b0;
    end else if (clk_en) begin
      if (done_st) begin
        angle_result <= cz_ff;
        magnitude_result <= cx_ff[DATA_W+1:0];
        result_valid <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      alert_conv_done <= 1'b0;
    end else if (clk_en) begin
      alert_conv_done <= done_st;
    end
  end

endmodule
`default_nettype wire

// ===== verification/agc_angle_axis_sva.sv
/* Checker on the angle block ports.
   Assumes clk_en is held high. */
`timescale 1ns/1ns
`default_nettype none
module agc_chk
  import agc_pkg::*;
#(
  parameter int DATA_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Watched ports
  input wire logic conv_done,
  input wire logic [AGC_ANG_W-1:0] angle_result,
  input wire logic [DATA_W+1:0] magnitude_result,
  input wire logic result_valid,
  input wire logic alert_conv_done
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!resetn);
  sequence s_quiet;
    !alert_conv_done [*8];
  endsequence
  a_alert_cause: assert property (alert_conv_done |-> $past(conv_done, 16))
    else $error("alert without start");
  a_first_answer: assert property (conv_done && !result_valid |-> ##16 alert_conv_done)
    else $error("alert late");
  a_alert_pulse: assert property (alert_conv_done |=> s_quiet)
    else $error("alert too long");
  a_angle_hold: assert property (!alert_conv_done |-> $stable(angle_result))
    else $error("angle moved");
  a_mag_hold: assert property (!alert_conv_done |-> $stable(magnitude_result))
    else $error("magnitude moved");
  a_valid_sticky: assert property (result_valid |=> result_valid)
    else $error("valid dropped");
  a_valid_rise: assert property ($rose(result_valid) |-> alert_conv_done)
    else $error("valid without alert");
  a_alert_valid: assert property (alert_conv_done |-> result_valid)
    else $error("alert without valid");
endmodule
bind agc_angle_axis agc_chk #(.DATA_W(DATA_W)) i_chk (.*);
`default_nettype wire

// ===== verification/agc_host_model.sv
/* Host model: latches the angle on the completion alert.
   Assumes the alert is a one-cycle pulse. */
`timescale 1ns/1ns
`default_nettype none
module agc_host_model
  import agc_pkg::*;
(
  // Device side
  input wire logic clk,
  input wire logic alert_conv_done,
  input wire logic [15:0] angle_result,
  // Calibration spans
  input wire logic [15:0] span_x,
  input wire logic [15:0] span_y,
  // Host view
  output logic [15:0] host_angle,
  output logic [1:0] calib_tgt,
  output logic [AGC_GAIN_W-1:0] calib_gain
);
  always_ff @(posedge clk) begin
    if (alert_conv_done) begin
      host_angle <= angle_result;
    end
  end
  // Gain target and code from the peak-to-peak spans
  always_comb begin
    calib_tgt = AGC_TGT_NONE;
    calib_gain = '0;
    if (span_y < span_x) begin
      calib_tgt = AGC_TGT_X;
      calib_gain = AGC_GAIN_W'((27'(span_y) << AGC_GAIN_SHIFT) / span_x);
    end else if (span_x < span_y) begin
      calib_tgt = AGC_TGT_Y;
      calib_gain = AGC_GAIN_W'((27'(span_x) << AGC_GAIN_SHIFT) / span_y);
    end
  end
endmodule
`default_nettype wire

// ===== verification/agc_angle_axis_tb.sv
/* Bench for the angle block with a host model.
   Assumes a 25 MHz clock; clk_en tied high. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module agc_angle_axis_tb;
  logic clk = 0, resetn = 0, cd = 0, vld, alert;
  logic [1:0] sel = 0, tgt = 0;
  logic [9:0] gv = 0;
  logic [15:0] ax = 0, ay = 0, az = 0, ang, hang;
  logic [15:0] spx = 16'h0000, spy = 16'h0000;
  logic [1:0] ctgt;
  logic [9:0] cgv;
  logic [17:0] mag;
  int n_errors = 0, total_checks = 0;
  always #20 clk = ~clk;
  agc_angle_axis i_dut (.clk(clk), .resetn(resetn), .clk_en(1'b1), .angle_axis_sel(sel),
    .gain_target_sel(tgt), .gain_value(gv), .conv_done(cd), .axis_x(ax), .axis_y(ay),
    .axis_z(az), .angle_result(ang), .magnitude_result(mag), .result_valid(vld),
    .alert_conv_done(alert));
  agc_host_model i_host (.clk(clk), .alert_conv_done(alert), .angle_result(ang),
    .span_x(spx), .span_y(spy), .host_angle(hang), .calib_tgt(ctgt), .calib_gain(cgv));
  function automatic logic [15:0] sec(input logic [15:0] a);
    return (a + 16'h0080) & 16'hFF00;
  endfunction
  task automatic conclude();
    $display("errors=%0d checks=%0d", n_errors, total_checks);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic conv(input logic [15:0] x, y, z, e);
    int i;
    ax = x;
    ay = y;
    az = z;
    cd = 1;
    @(negedge clk) cd = 0;
    for (i = 1; i < 40 && alert !== 1'b1; i++) @(negedge clk);
    if (i > 39) begin
      n_errors++;
      conclude();
    end
    `CHK(i, 16)
    `CHK(vld, 1'b1)
    `CHK(sec(ang), sec(e))
    @(negedge clk);
    `CHK(sec(hang), sec(e))
    `CHK(alert, 1'b0)
  endtask
  task automatic t_circle();
    sel = 2'h1;
    conv(16'h03E8, 16'h0000, 16'h0000, 16'h0000);
    `CHK(mag > 18'h0_0654 && mag < 18'h0_0686, 1'b1)
    conv(16'h0000, 16'h03E8, 16'h0000, 16'h4000);
    `CHK(mag > 18'h0_0654 && mag < 18'h0_0686, 1'b1)
    conv(16'hFC18, 16'h0000, 16'h0000, 16'h8000);
    `CHK(mag > 18'h0_0654 && mag < 18'h0_0686, 1'b1)
    conv(16'h0000, 16'hFC18, 16'h0000, 16'hC000);
    `CHK(mag > 18'h0_0654 && mag < 18'h0_0686, 1'b1)
  endtask
  task automatic t_pairs();
    sel = 2'h2;
    conv(16'h03E8, 16'h0000, 16'h03E8, 16'h4000);
    sel = 2'h3;
    conv(16'hFC18, 16'h01F4, 16'h0000, 16'h8000);
  endtask
  task automatic t_gain();
    sel = 2'h0;
    gv = 10'h200;
    tgt = 2'h1;
    conv(16'h03E8, 16'h03E8, 16'h0000, 16'h2D1C);
    tgt = 2'h2;
    conv(16'h03E8, 16'h03E8, 16'h0000, 16'h12E4);
    tgt = 2'h0;
    conv(16'h03E8, 16'h03E8, 16'h0000, 16'h2000);
    tgt = 2'h3;
    conv(16'h03E8, 16'h03E8, 16'h0000, 16'h2000);
  endtask
  task automatic t_calib();
    sel = 2'h1;
    spx = 16'hEA60;
    spy = 16'hAFC8;
    @(negedge clk);
    `CHK({ctgt, cgv}, {2'h1, 10'h300})
    tgt = ctgt;
    gv = cgv;
    conv(16'h03E8, 16'h02EE, 16'h0000, 16'h2000);
    spx = 16'hAFC8;
    spy = 16'hEA60;
    @(negedge clk);
    `CHK({ctgt, cgv}, {2'h2, 10'h300})
    tgt = ctgt;
    gv = cgv;
    conv(16'h02EE, 16'h03E8, 16'h0000, 16'h2000);
    spx = 16'hEA60;
    @(negedge clk);
    `CHK(ctgt, 2'h0)
  endtask
  initial begin
    repeat (10) @(negedge clk);
    resetn = 1;
    @(negedge clk);
    `CHK({vld, alert, ang}, 18'h0_0000)
    t_circle();
    t_pairs();
    t_gain();
    t_calib();
    conclude();
  end
endmodule
`default_nettype wire
